// ### ext_irq_pkg.sv
// Purpose: Constants for the external interrupt input block
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses
// Notes: Config register sits at its printed offset
package ext_irq_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CONFIG_OFS = 8'hE4;
	localparam logic [7:0] TIMER_CTRL_OFS = 8'h88;
	localparam logic [7:0] MASK_OFS = 8'hA8;
	localparam logic [7:0] STATUS_OFS = 8'hF0;
	localparam logic [7:0] IRQ_MASK_OFS = 8'hF4;
	localparam logic [7:0] CONFIG_RESET = 8'h01;
	localparam int CH1_POL_BIT = 7;
	localparam int CH1_SEL_LSB = 4;
	localparam int CH0_POL_BIT = 3;
	localparam int CH0_SEL_LSB = 0;
	localparam int CH0_EDGE_BIT = 0;
	localparam int CH0_PEND_BIT = 1;
	localparam int CH1_EDGE_BIT = 2;
	localparam int CH1_PEND_BIT = 3;
	localparam int CH0_MASK_BIT = 0;
	localparam int CH1_MASK_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### external_interrupt_inputs.sv
// Purpose: Two external interrupt channels on selectable port 0 pins
// Assumes: Port pins asynchronous to clk; CPU pulses vector acknowledge
// Notes: Pins are only observed, never driven
//
// What this block does
// - Polarity bit 0 means active low, 1 means active high.
// - Edge select 1 detects edges, 0 samples the level.
// - Three-bit selector picks port 0 pin 0 to 7 for each channel.
// - Channel only watches its pin and never disturbs crossbar peripherals.
// - Crossbar skip bit set keeps the pin away from peripherals.
// - Pending flags live in timer control bits 1 and 3.
// - Edge mode: active edge sets pending, CPU vector clears it.
// - Level mode: pending simply mirrors the active input, no storage.
// - Config: ch1 polarity 7, ch1 select 6-4, ch0 polarity 3, ch0 select 2-0.
// - ext_irq_chan0 and ext_irq_chan1 reach CPU only when enable mask bit 0 or 2 is set; irq is status gated by irq_mask.
`timescale 1ns/1ps
module external_interrupt_inputs #(
	parameter int PIN_COUNT = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Port 0 pins, observed only; crossbar requests in, grants out gated by skip
	input wire logic [PIN_COUNT-1:0] port0_pin,
	input wire logic [PIN_COUNT-1:0] port0_skip_reg,
	input wire logic [PIN_COUNT-1:0] periph_request,
	output logic [PIN_COUNT-1:0] periph_grant,
	// CPU vectoring
	input wire logic chan0_vector_ack,
	input wire logic chan1_vector_ack,
	output logic ext_irq_chan0,
	output logic ext_irq_chan1,
	output logic irq,
	// AXI4-Lite write
	input wire logic [ext_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ext_irq_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		logic [PIN_COUNT-1:0] sync1;
		logic [PIN_COUNT-1:0] sync2;
		logic [1:0] act_prev;
		logic [1:0] edge_pend;
		logic [7:0] config_reg;
		logic [1:0] edge_sel;
		logic [1:0] mask;
		logic [1:0] status;
		logic [1:0] irq_mask;
		logic aw_held;
		logic [ext_irq_pkg::ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	state_t st;
	state_t next_st;
	logic [2:0] sel0;
	logic [2:0] sel1;
	logic [1:0] active;
	logic [1:0] pending;
	logic [1:0] ack;
	logic do_write;
	logic do_read;

	// ----------------------------------------
	// Pin selection and detection
	// ----------------------------------------
	assign sel0 = st.config_reg[ext_irq_pkg::CH0_SEL_LSB +: 3];
	assign sel1 = st.config_reg[ext_irq_pkg::CH1_SEL_LSB +: 3];
	assign ack = {chan1_vector_ack, chan0_vector_ack};
	// Polarity 0 inverts the pin so that active is always high
	assign active[0] = st.sync2[sel0] ~^ st.config_reg[ext_irq_pkg::CH0_POL_BIT];
	assign active[1] = st.sync2[sel1] ~^ st.config_reg[ext_irq_pkg::CH1_POL_BIT];
	// Level mode mirrors the input; edge mode uses the stored flag
	assign pending[0] = st.edge_sel[0] ? st.edge_pend[0] : active[0];
	assign pending[1] = st.edge_sel[1] ? st.edge_pend[1] : active[1];
	assign ext_irq_chan0 = pending[0] & st.mask[0];
	assign ext_irq_chan1 = pending[1] & st.mask[1];
	assign irq = |(st.status & st.irq_mask);
	// Skipped pins are never granted to a peripheral
	assign periph_grant = periph_request & ~port0_skip_reg;

	assign s_axi_awready = ~st.aw_held & ~st.bvalid;
	assign s_axi_wready = ~st.w_held & ~st.bvalid;
	assign s_axi_arready = ~st.rvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [ext_irq_pkg::ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] rise;
		logic [1:0] wclr;
		logic [31:0] rd;
		logic rok;
		next_st = st;
		waddr = st.aw_held ? st.aw_addr : s_axi_awaddr;
		wdata = st.w_held ? st.w_data : s_axi_wdata;
		wstrb = st.w_held ? st.w_strb : s_axi_wstrb;
		wclr = 2'h0;
		rd = 32'h0;
		rok = 1'b1;
		next_st.sync1 = port0_pin;
		next_st.sync2 = st.sync1;
		next_st.act_prev = active;
		rise = active & ~st.act_prev;
		// Write channel capture
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		do_write = (st.aw_held | (s_axi_awvalid & s_axi_awready)) &
			(st.w_held | (s_axi_wvalid & s_axi_wready)) & ~st.bvalid;
		// Edge pending: CPU ack clears, a new edge wins over clear
		for (int c = 0; c < 2; c++) begin
			if (ack[c]) begin
				next_st.edge_pend[c] = 1'b0;
			end
			if (rise[c]) begin
				next_st.edge_pend[c] = 1'b1;
			end
		end
		if (do_write) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = ext_irq_pkg::RESP_OKAY;
			if (!wstrb[0]) begin
				// Upper lanes only: nothing to store
			end else if (waddr == ext_irq_pkg::CONFIG_OFS) begin
				next_st.config_reg = wdata[7:0];
			end else if (waddr == ext_irq_pkg::TIMER_CTRL_OFS) begin
				next_st.edge_sel[0] = wdata[ext_irq_pkg::CH0_EDGE_BIT];
				next_st.edge_sel[1] = wdata[ext_irq_pkg::CH1_EDGE_BIT];
				// Software may clear an edge flag; a same-cycle edge still wins
				if (!wdata[ext_irq_pkg::CH0_PEND_BIT] && !rise[0]) begin
					next_st.edge_pend[0] = 1'b0;
				end
				if (!wdata[ext_irq_pkg::CH1_PEND_BIT] && !rise[1]) begin
					next_st.edge_pend[1] = 1'b0;
				end
			end else if (waddr == ext_irq_pkg::MASK_OFS) begin
				next_st.mask[0] = wdata[ext_irq_pkg::CH0_MASK_BIT];
				next_st.mask[1] = wdata[ext_irq_pkg::CH1_MASK_BIT];
			end else if (waddr == ext_irq_pkg::STATUS_OFS) begin
				wclr = wdata[1:0];
			end else if (waddr == ext_irq_pkg::IRQ_MASK_OFS) begin
				next_st.irq_mask = wdata[1:0];
			end else begin
				next_st.bresp = ext_irq_pkg::RESP_SLVERR;
			end
		end
		// Sticky status: write one clears, new event wins
		next_st.status = (st.status & ~wclr) | rise;
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Read path
		do_read = s_axi_arvalid & ~st.rvalid;
		case (s_axi_araddr)
			ext_irq_pkg::CONFIG_OFS: rd = {24'h0, st.config_reg};
			ext_irq_pkg::TIMER_CTRL_OFS: begin
				rd[ext_irq_pkg::CH0_EDGE_BIT] = st.edge_sel[0];
				rd[ext_irq_pkg::CH0_PEND_BIT] = pending[0];
				rd[ext_irq_pkg::CH1_EDGE_BIT] = st.edge_sel[1];
				rd[ext_irq_pkg::CH1_PEND_BIT] = pending[1];
			end
			ext_irq_pkg::MASK_OFS: begin
				rd[ext_irq_pkg::CH0_MASK_BIT] = st.mask[0];
				rd[ext_irq_pkg::CH1_MASK_BIT] = st.mask[1];
			end
			ext_irq_pkg::STATUS_OFS: rd = {30'h0, st.status};
			ext_irq_pkg::IRQ_MASK_OFS: rd = {30'h0, st.irq_mask};
			default: rok = 1'b0;
		endcase
		if (do_read) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd;
			next_st.rresp = rok ? ext_irq_pkg::RESP_OKAY : ext_irq_pkg::RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			// Pins idle high; starting the synchroniser low would fake an edge
			st.sync1 <= '1;
			st.sync2 <= '1;
			st.config_reg <= ext_irq_pkg::CONFIG_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	edge_sets_pend_a: assert property (@(posedge clk) disable iff (sys_rst)
		(st.edge_sel[0] && active[0] && !st.act_prev[0]) |=> st.edge_pend[0])
		else $error("edge did not set channel 0 pending");
	ack_clears_pend_a: assert property (@(posedge clk) disable iff (sys_rst)
		(chan0_vector_ack && !(active[0] && !st.act_prev[0])) |=> !st.edge_pend[0])
		else $error("vector ack did not clear channel 0 pending");
	level_mirror_a: assert property (@(posedge clk) disable iff (sys_rst)
		!st.edge_sel[1] |-> (pending[1] == active[1]))
		else $error("level pending does not follow input");
	polarity_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		!st.config_reg[ext_irq_pkg::CH0_POL_BIT] |-> (active[0] == !st.sync2[sel0]))
		else $error("active low polarity wrong");
	mask_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		!st.mask[1] |-> !ext_irq_chan1)
		else $error("masked channel reached cpu");
	sync_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |-> ##2 (st.sync2 == $past(port0_pin, 2)))
		else $error("pin synchroniser depth wrong");
	skip_grant_a: assert property (@(posedge clk) disable iff (sys_rst)
		(periph_grant & port0_skip_reg) == '0)
		else $error("skipped pin granted");
	config_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		(do_write && s_axi_awvalid && !st.aw_held && s_axi_awaddr == ext_irq_pkg::CONFIG_OFS
		&& s_axi_wvalid && !st.w_held && s_axi_wstrb[0]) |=> (st.config_reg == $past(s_axi_wdata[7:0])))
		else $error("config write not stored");
	edge_sets_pend1_a: assert property (@(posedge clk) disable iff (sys_rst)
		(st.edge_sel[1] && active[1] && !st.act_prev[1]) |=> st.edge_pend[1])
		else $error("edge did not set channel 1 pending");
	ack_clears_pend1_a: assert property (@(posedge clk) disable iff (sys_rst)
		(chan1_vector_ack && !(active[1] && !st.act_prev[1])) |=> !st.edge_pend[1])
		else $error("vector ack did not clear channel 1 pending");
	level_mirror0_a: assert property (@(posedge clk) disable iff (sys_rst)
		!st.edge_sel[0] |-> (pending[0] == active[0]))
		else $error("level pending does not follow input");
	edge_pending1_a: assert property (@(posedge clk) disable iff (sys_rst)
		st.edge_sel[1] |-> (pending[1] == st.edge_pend[1]))
		else $error("edge mode pending not stored flag");
	polarity_high_a: assert property (@(posedge clk) disable iff (sys_rst)
		st.config_reg[ext_irq_pkg::CH1_POL_BIT] |-> (active[1] == st.sync2[sel1]))
		else $error("active high polarity wrong");
	mask_gate0_a: assert property (@(posedge clk) disable iff (sys_rst)
		!st.mask[0] |-> !ext_irq_chan0)
		else $error("masked channel reached cpu");
	unmasked_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		(st.mask[0] && pending[0]) |-> ext_irq_chan0)
		else $error("enabled request did not reach cpu");
	skip_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		(periph_grant & ~port0_skip_reg) == (periph_request & ~port0_skip_reg))
		else $error("unskipped pin grant disturbed");
	sync_first_a: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> (st.sync1 == $past(port0_pin)))
		else $error("first synchroniser stage wrong");
	pend_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("read data dropped before taken");
	resp_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
		else $error("write response dropped before taken");
	level_set0_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!st.edge_sel[0] && active[0]) |-> pending[0])
		else $error("active level not pending");
endmodule

// ### ext_irq_source.sv
// Purpose: External interrupt sources on port 0 pins
// Assumes: Sources change just after a bench clock edge
// Notes: Pins idle high, as open-drain with latch set
`timescale 1ns/1ps
module ext_irq_source (
	// Clock
	input wire logic clk,
	// Requested levels and pins
	input wire logic [7:0] level_req,
	output logic [7:0] port0_pin
);
	// Pulled high until the first request lands
	initial port0_pin = 8'hFF;
	// Pin follows the requested level, one clock edge later
	always @(posedge clk) begin
		port0_pin <= level_req;
	end
endmodule

// ### external_interrupt_inputs_tb.sv
// Purpose: Self-checking bench for the external interrupt block
// Assumes: AXI4-Lite master tasks, one access at a time
// Notes: Fixed waits cover the pin synchroniser delay
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("BAD %0t %h %h", $time, (a), (e)); end end
module external_interrupt_inputs_tb;
	logic clk, sys_rst, ack0, ack1, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq0, irq1, irq;
	logic [7:0] req, pins, skip, preq, grant, awaddr, araddr, rd;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, resp;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	ext_irq_source u_ext_irq_source (.clk(clk), .level_req(req), .port0_pin(pins));
	external_interrupt_inputs u_external_interrupt_inputs (.clk(clk), .sys_rst(sys_rst), .port0_pin(pins),
		.port0_skip_reg(skip), .periph_request(preq), .periph_grant(grant), .chan0_vector_ack(ack0),
		.chan1_vector_ack(ack1), .ext_irq_chan0(irq0), .ext_irq_chan1(irq1), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task tally_and_finish;
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			tally_and_finish;
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				resp = bresp;
				break;
			end
		end
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				rd = rdata[7:0];
				resp = rresp;
				break;
			end
		end
	endtask
	// ----------------
	// Test sequence
	// ----------------
	initial begin
		{sys_rst, ack0, ack1, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
		{req, skip, preq, awaddr, araddr} = 40'hFB24FF0000;
		wdata = 32'h00000000;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rdr(ext_irq_pkg::CONFIG_OFS);
		`CHK(rd, ext_irq_pkg::CONFIG_RESET)
		`CHK(grant, 8'hDB)
		wr(ext_irq_pkg::CONFIG_OFS, 8'h5A);
		rdr(ext_irq_pkg::CONFIG_OFS);
		`CHK(rd, 8'h5A)
		rdr(8'h10);
		`CHK(resp, ext_irq_pkg::RESP_SLVERR)
		wr(8'h10, 8'h00);
		`CHK(resp, ext_irq_pkg::RESP_SLVERR)
		wr(ext_irq_pkg::MASK_OFS, 8'h05);
		rdr(ext_irq_pkg::TIMER_CTRL_OFS);
		`CHK(rd, 8'h00)
		req <= 8'hFF;
		repeat (6) @(posedge clk);
		`CHK(irq0, 1'b1)
		rdr(ext_irq_pkg::TIMER_CTRL_OFS);
		`CHK(rd, 8'h02)
		req <= 8'hFB;
		repeat (6) @(posedge clk);
		`CHK(irq0, 1'b0)
		wr(ext_irq_pkg::TIMER_CTRL_OFS, 8'h05);
		req <= 8'hDB;
		repeat (6) @(posedge clk);
		req <= 8'hFB;
		repeat (6) @(posedge clk);
		`CHK(irq1, 1'b1)
		rdr(ext_irq_pkg::TIMER_CTRL_OFS);
		`CHK(rd & 8'h0C, 8'h0C)
		wr(ext_irq_pkg::MASK_OFS, 8'h01);
		`CHK(irq1, 1'b0)
		@(posedge clk);
		ack1 <= 1'b1;
		@(posedge clk);
		ack1 <= 1'b0;
		rdr(ext_irq_pkg::TIMER_CTRL_OFS);
		`CHK(rd & 8'h08, 8'h00)
		`CHK(irq, 1'b0)
		rdr(ext_irq_pkg::STATUS_OFS);
		`CHK(rd, 8'h03)
		wr(ext_irq_pkg::IRQ_MASK_OFS, 8'h01);
		`CHK(irq, 1'b1)
		wr(ext_irq_pkg::STATUS_OFS, 8'h01);
		`CHK(irq, 1'b0)
		`CHK(resp, ext_irq_pkg::RESP_OKAY)
		req <= 8'hFF;
		repeat (6) @(posedge clk);
		`CHK(irq0, 1'b1)
		ack0 <= 1'b1;
		@(posedge clk);
		ack0 <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(irq0, 1'b0)
		tally_and_finish;
	end
endmodule
